// *** design/mcu_instruction_execute.sv ***
// decode and execute core for the 14-bit instruction word
`default_nettype none
// Summary of operation
// - add with carry sums accumulator, file and carry; sets carry, half carry, zero
// - subtract with borrow takes accumulator and borrow from file; sets C, half carry, Z
// - rotate left through carry: old top bit to carry, carry into bit 0
// - rotate right through carry: old bit 0 to carry, carry into top bit
// - destination 0 writes the accumulator, 1 writes the file register
// - decrement or increment file, skip next when zero, flags untouched
// - bit test skips next when bit clear or set as asked, flags untouched
// - pc change or true skip costs two cycles, second one a no-op
// - indirect slot with pointer top bit set adds one cycle
// - return with literal loads accumulator, pc from stack top, two cycles
// - plain return pops stack into pc, two cycles, flags untouched
// - page latch load copies seven-bit literal in one cycle, no flags
// - literal or, and, xor into accumulator, only Z changes
// - literal minus accumulator into accumulator, sets C, half carry, Z
module mcu_instruction_execute
	import exec_pkg::*;
#(
	parameter int STACK_DEPTH = STACK_DEPTH_DEF
) (
	input wire logic clk,
	input wire logic rst,
	output logic [PC_W-1:0] pm_addr,
	input wire logic [WORD_W-1:0] pm_word,
	input wire logic [BUS_AW-1:0] reg_addr,
	input wire logic [BUS_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [BUS_DW-1:0] reg_rdata,
	output logic retire
);

	////////////////////////////////////////////////////////////////////////////////
	// state

	logic run_q;
	logic [DATA_W-1:0] acc_q;
	logic [2:0] flags_q;
	logic [LATCH_W-1:0] latch_q;
	logic [PC_W-1:0] pc_q;
	logic [FILE_AW-1:0] fsel_q;
	logic [CYC_W-1:0] cycles_q;
	logic [BUS_DW-1:0] rdata_q;
	logic [DATA_W-1:0] fmem_q [2**FILE_AW];
	exec_state_t state_q;

	////////////////////////////////////////////////////////////////////////////////
	// decode

	logic [WORD_W-1:0] ir;
	logic [5:0] op;
	logic [FILE_AW-1:0] fa;
	logic [FILE_AW-1:0] eff_addr;
	logic dest;
	logic [DATA_W-1:0] lit;
	logic [2:0] bsel;
	logic [DATA_W-1:0] ptr;
	logic [DATA_W-1:0] fval;
	logic is_bit_test;
	logic is_file_op;
	logic needs_extra;
	logic exec_go;
	logic halted_wr;

	assign ir = pm_word;
	assign op = ir[WORD_W-1:OP_LSB];
	assign fa = ir[FILE_AW-1:0];
	assign dest = ir[DEST_POS];
	assign lit = ir[DATA_W-1:0];
	assign bsel = ir[BOP_LSB-1:BIT_LSB];
	assign ptr = fmem_q[ADDR_POINTER_REGISTER];
	assign eff_addr = (fa == ADDR_INDIRECT_SLOT) ? ptr[FILE_AW-1:0] : fa;
	assign fval = fmem_q[eff_addr];
	assign is_bit_test = (ir[WORD_W-1:BOP_LSB] == OP_BIT_TEST_SKIP_CLEAR)
		|| (ir[WORD_W-1:BOP_LSB] == OP_BIT_TEST_SKIP_SET);
	assign is_file_op = is_bit_test || (op == OP_ADD_CARRY_FILE)
		|| (op == OP_SUB_BORROW_FILE) || (op == OP_ROTATE_LEFT_CARRY)
		|| (op == OP_ROTATE_RIGHT_CARRY) || (op == OP_DEC_SKIP_ZERO)
		|| (op == OP_INC_SKIP_ZERO);
	assign needs_extra = is_file_op && (fa == ADDR_INDIRECT_SLOT) && ptr[DATA_W-1]
		&& (state_q == ST_EXEC);
	assign exec_go = run_q && (((state_q == ST_EXEC) && !needs_extra)
		|| (state_q == ST_EXTRA));
	assign halted_wr = reg_wr && !run_q;

	////////////////////////////////////////////////////////////////////////////////
	// arithmetic

	logic [DATA_W-1:0] alu_a;
	logic [DATA_W-1:0] alu_b;
	logic alu_cin;
	logic [DATA_W-1:0] alu_sum;
	logic alu_c;
	logic alu_half;

	always_comb begin
		alu_a = acc_q;
		alu_b = fval;
		alu_cin = flags_q[FLAG_C];
		if (op == OP_SUB_BORROW_FILE) begin
			alu_a = fval;
			alu_b = ~acc_q;
		end else if (op == OP_LITERAL_MINUS_ACC) begin
			alu_a = lit;
			alu_b = ~acc_q;
			alu_cin = 1'b1;
		end
	end

	exec_adder u_adder (
		.a(alu_a),
		.b(alu_b),
		.cin(alu_cin),
		.sum(alu_sum),
		.cout(alu_c),
		.half(alu_half)
	);

	////////////////////////////////////////////////////////////////////////////////
	// execute

	logic [DATA_W-1:0] res;
	logic wr_dest;
	logic wr_acc;
	logic [2:0] flags_d;
	logic skip;
	logic jump;
	logic latch_wr;
	logic known;

	always_comb begin
		res = fval;
		wr_dest = 1'b0;
		wr_acc = 1'b0;
		flags_d = flags_q;
		skip = 1'b0;
		jump = 1'b0;
		latch_wr = 1'b0;
		known = 1'b1;
		case (op)
			OP_ADD_CARRY_FILE, OP_SUB_BORROW_FILE: begin
				res = alu_sum;
				wr_dest = 1'b1;
				flags_d[FLAG_C] = alu_c;
				flags_d[FLAG_HALF] = alu_half;
				flags_d[FLAG_Z] = (alu_sum == '0);
			end
			OP_ROTATE_LEFT_CARRY: begin
				res = {fval[DATA_W-2:0], flags_q[FLAG_C]};
				wr_dest = 1'b1;
				flags_d[FLAG_C] = fval[DATA_W-1];
			end
			OP_ROTATE_RIGHT_CARRY: begin
				res = {flags_q[FLAG_C], fval[DATA_W-1:1]};
				wr_dest = 1'b1;
				flags_d[FLAG_C] = fval[0];
			end
			OP_DEC_SKIP_ZERO, OP_INC_SKIP_ZERO: begin
				res = (op == OP_INC_SKIP_ZERO) ? fval + 8'h01 : fval - 8'h01;
				wr_dest = 1'b1;
				skip = (res == '0);
			end
			OP_LITERAL_OR, OP_LITERAL_AND, OP_LITERAL_XOR: begin
				case (op)
					OP_LITERAL_OR: res = acc_q | lit;
					OP_LITERAL_AND: res = acc_q & lit;
					default: res = acc_q ^ lit;
				endcase
				wr_acc = 1'b1;
				flags_d[FLAG_Z] = (res == '0);
			end
			OP_LITERAL_MINUS_ACC: begin
				res = alu_sum;
				wr_acc = 1'b1;
				flags_d[FLAG_C] = alu_c;
				flags_d[FLAG_HALF] = alu_half;
				flags_d[FLAG_Z] = (alu_sum == '0);
			end
			OP_RETURN_WITH_LITERAL: begin
				res = lit;
				wr_acc = 1'b1;
				jump = 1'b1;
			end
			default: begin
				if (is_bit_test) begin
					skip = fval[bsel] == ir[BOP_LSB];
				end else if (ir[WORD_W-1:BIT_LSB] == OP_LITERAL_TO_PAGE_LATCH) begin
					latch_wr = 1'b1;
				end else if (ir == OP_RETURN) begin
					jump = 1'b1;
				end else begin
					known = 1'b0;
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// return stack

	logic [PC_W-1:0] stack_top;
	logic push;

	assign push = halted_wr && (reg_addr == REG_STACK_PUSH);

	exec_stack #(
		.DEPTH(STACK_DEPTH)
	) u_stack (
		.clk(clk),
		.rst(rst),
		.push(push),
		.pop(exec_go && jump),
		.push_val(reg_wdata[PC_W-1:0]),
		.top(stack_top)
	);

	////////////////////////////////////////////////////////////////////////////////
	// sequencing

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= ST_EXEC;
			pc_q <= '0;
		end else if (exec_go) begin
			if (jump) begin
				pc_q <= stack_top;
				state_q <= ST_FLUSH;
			end else begin
				pc_q <= pc_q + 15'h0001;
				state_q <= skip ? ST_SKIP : ST_EXEC;
			end
		end else if (run_q) begin
			case (state_q)
				ST_EXEC: state_q <= ST_EXTRA;
				ST_SKIP: begin
					pc_q <= pc_q + 15'h0001;
					state_q <= ST_EXEC;
				end
				default: state_q <= ST_EXEC;
			endcase
		end
	end

	assign pm_addr = pc_q;
	assign retire = exec_go;

	always_ff @(posedge clk) begin
		if (rst) begin
			cycles_q <= '0;
		end else if (run_q) begin
			cycles_q <= cycles_q + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// working registers

	always_ff @(posedge clk) begin
		if (rst) begin
			acc_q <= '0;
			flags_q <= '0;
		end else if (exec_go) begin
			if (wr_acc || (wr_dest && !dest)) begin
				acc_q <= res;
			end
			flags_q <= flags_d;
		end else if (halted_wr && (reg_addr == REG_ACC)) begin
			acc_q <= reg_wdata[DATA_W-1:0];
		end else if (halted_wr && (reg_addr == REG_STATUS)) begin
			flags_q <= reg_wdata[2:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			latch_q <= '0;
		end else if (exec_go && latch_wr) begin
			latch_q <= ir[LATCH_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < 2**FILE_AW; i++) begin
				fmem_q[i] <= '0;
			end
		end else if (exec_go && wr_dest && dest) begin
			fmem_q[eff_addr] <= res;
		end else if (halted_wr && (reg_addr == REG_FILE_DATA)) begin
			fmem_q[fsel_q] <= reg_wdata[DATA_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register port

	always_ff @(posedge clk) begin
		if (rst) begin
			run_q <= CTRL_RUN_RESET;
			fsel_q <= '0;
		end else if (reg_wr && (reg_addr == REG_CTRL)) begin
			run_q <= reg_wdata[CTRL_RUN];
		end else if (halted_wr && (reg_addr == REG_FILE_SEL)) begin
			fsel_q <= reg_wdata[FILE_AW-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst || !reg_rd) begin
			rdata_q <= '0;
		end else begin
			case (reg_addr)
				REG_CTRL: rdata_q <= BUS_DW'(run_q);
				REG_ACC: rdata_q <= BUS_DW'(acc_q);
				REG_STATUS: rdata_q <= BUS_DW'(flags_q);
				REG_PC_HIGH_LATCH: rdata_q <= BUS_DW'(latch_q);
				REG_PC: rdata_q <= BUS_DW'(pc_q);
				REG_FILE_SEL: rdata_q <= BUS_DW'(fsel_q);
				REG_FILE_DATA: rdata_q <= BUS_DW'(fmem_q[fsel_q]);
				REG_CYCLES: rdata_q <= cycles_q;
				default: rdata_q <= '0;
			endcase
		end
	end

	assign reg_rdata = rdata_q;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	logic go_op_rl;
	logic go_op_rr;
	assign go_op_rl = exec_go && (op == OP_ROTATE_LEFT_CARRY);
	assign go_op_rr = exec_go && (op == OP_ROTATE_RIGHT_CARRY);

	property p_add_carry;
		exec_go && (op == OP_ADD_CARRY_FILE) && !dest && !$past(rst)
		|=> acc_q == $past(alu_sum) && flags_q[FLAG_Z] == (acc_q == '0);
	endproperty
	a_add_carry: assert property (p_add_carry) else $error("add carry result wrong");

	property p_rotate_left;
		go_op_rl |=> flags_q[FLAG_C] == $past(fval[DATA_W-1])
			&& flags_q[FLAG_Z] == $past(flags_q[FLAG_Z]);
	endproperty
	a_rotate_left: assert property (p_rotate_left) else $error("rotate left carry wrong");

	property p_rotate_right;
		go_op_rr && !dest |=> flags_q[FLAG_C] == $past(fval[0])
			&& acc_q[DATA_W-1] == $past(flags_q[FLAG_C]);
	endproperty
	a_rotate_right: assert property (p_rotate_right) else $error("rotate right wrong");

	property p_count_skip_flags;
		exec_go && ((op == OP_DEC_SKIP_ZERO) || (op == OP_INC_SKIP_ZERO))
		|=> $stable(flags_q);
	endproperty
	a_count_skip_flags: assert property (p_count_skip_flags) else $error("skip op hit flags");

	property p_skip_two_cycles;
		exec_go && skip |=> state_q == ST_SKIP && !retire ##1 state_q == ST_EXEC
			&& pc_q == $past(pc_q, 2) + 15'h0002;
	endproperty
	a_skip_two_cycles: assert property (p_skip_two_cycles) else $error("skip timing wrong");

	property p_jump_flush;
		exec_go && jump |=> state_q == ST_FLUSH && pc_q == $past(stack_top)
			&& $stable(flags_q) ##1 !$past(retire);
	endproperty
	a_jump_flush: assert property (p_jump_flush) else $error("return timing wrong");

	property p_indirect_extra;
		run_q && needs_extra |=> state_q == ST_EXTRA && $stable(pc_q) && $stable(acc_q);
	endproperty
	a_indirect_extra: assert property (p_indirect_extra) else $error("no extra cycle");

	property p_ret_literal;
		exec_go && (op == OP_RETURN_WITH_LITERAL) |=> acc_q == $past(lit);
	endproperty
	a_ret_literal: assert property (p_ret_literal) else $error("return literal wrong");

	property p_page_latch;
		exec_go && latch_wr |=> latch_q == $past(ir[LATCH_W-1:0]) && $stable(flags_q);
	endproperty
	a_page_latch: assert property (p_page_latch) else $error("page latch wrong");

	property p_literal_logic;
		exec_go && ((op == OP_LITERAL_OR) || (op == OP_LITERAL_AND) || (op == OP_LITERAL_XOR))
		|=> flags_q[FLAG_Z] == (acc_q == '0) && flags_q[1:0] == $past(flags_q[1:0]);
	endproperty
	a_literal_logic: assert property (p_literal_logic) else $error("literal logic wrong");

	property p_unknown_nop;
		exec_go && !known |=> $stable(acc_q) && $stable(flags_q)
			&& pc_q == $past(pc_q) + 15'h0001 && state_q == ST_EXEC;
	endproperty
	a_unknown_nop: assert property (p_unknown_nop) else $error("unknown word not a no-op");

	c_skip: cover property (exec_go && skip);
	c_return: cover property (exec_go && jump);
	c_extra: cover property (state_q == ST_EXTRA);
	c_sub_literal: cover property (exec_go && (op == OP_LITERAL_MINUS_ACC));

endmodule : mcu_instruction_execute
`default_nettype wire

// *** design/exec_pkg.sv ***
// constants and types shared by the instruction execute core
`default_nettype none
package exec_pkg;

	// widths
	localparam int WORD_W = 14;
	localparam int DATA_W = 8;
	localparam int PC_W = 15;
	localparam int FILE_AW = 7;
	localparam int LATCH_W = 7;
	localparam int BUS_AW = 4;
	localparam int BUS_DW = 16;
	localparam int CYC_W = 16;
	localparam int STACK_DEPTH_DEF = 16;

	// instruction fields
	localparam int DEST_POS = 7;
	localparam int BIT_LSB = 7;
	localparam int OP_LSB = 8;
	localparam int BOP_LSB = 10;

	// six-bit major opcodes, bits 13..8
	localparam logic [5:0] OP_ADD_CARRY_FILE = 6'h3d;
	localparam logic [5:0] OP_SUB_BORROW_FILE = 6'h3b;
	localparam logic [5:0] OP_ROTATE_LEFT_CARRY = 6'h0d;
	localparam logic [5:0] OP_ROTATE_RIGHT_CARRY = 6'h0c;
	localparam logic [5:0] OP_DEC_SKIP_ZERO = 6'h0b;
	localparam logic [5:0] OP_INC_SKIP_ZERO = 6'h0f;
	localparam logic [5:0] OP_LITERAL_OR = 6'h38;
	localparam logic [5:0] OP_LITERAL_AND = 6'h39;
	localparam logic [5:0] OP_LITERAL_XOR = 6'h3a;
	localparam logic [5:0] OP_LITERAL_MINUS_ACC = 6'h3c;
	localparam logic [5:0] OP_RETURN_WITH_LITERAL = 6'h34;
	// four-bit bit-test opcodes, bits 13..10
	localparam logic [3:0] OP_BIT_TEST_SKIP_CLEAR = 4'h6;
	localparam logic [3:0] OP_BIT_TEST_SKIP_SET = 4'h7;
	// seven-bit opcode, bits 13..7
	localparam logic [6:0] OP_LITERAL_TO_PAGE_LATCH = 7'h63;
	// whole word
	localparam logic [13:0] OP_RETURN = 14'h0008;

	// status bit positions
	localparam int FLAG_C = 0;
	localparam int FLAG_HALF = 1;
	localparam int FLAG_Z = 2;

	// file map
	localparam logic [6:0] ADDR_INDIRECT_SLOT = 7'h00;
	localparam logic [6:0] ADDR_POINTER_REGISTER = 7'h04;

	// register port offsets
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_ACC = 4'h1;
	localparam logic [3:0] REG_STATUS = 4'h2;
	localparam logic [3:0] REG_PC_HIGH_LATCH = 4'h3;
	localparam logic [3:0] REG_PC = 4'h4;
	localparam logic [3:0] REG_STACK_PUSH = 4'h5;
	localparam logic [3:0] REG_FILE_SEL = 4'h6;
	localparam logic [3:0] REG_FILE_DATA = 4'h7;
	localparam logic [3:0] REG_CYCLES = 4'h8;
	localparam int CTRL_RUN = 0;
	localparam logic CTRL_RUN_RESET = 1'b0;

	typedef enum logic [1:0] {ST_EXEC, ST_SKIP, ST_FLUSH, ST_EXTRA} exec_state_t;

endpackage : exec_pkg
`default_nettype wire

// *** design/exec_adder.sv ***
// eight-bit adder with carry and half carry outputs
`default_nettype none
module exec_adder
	import exec_pkg::*;
(
	input wire logic [DATA_W-1:0] a,
	input wire logic [DATA_W-1:0] b,
	input wire logic cin,
	output logic [DATA_W-1:0] sum,
	output logic cout,
	output logic half
);
	logic [DATA_W:0] full;
	logic [4:0] low;

	always_comb begin
		full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		sum = full[DATA_W-1:0];
		cout = full[DATA_W];
		half = low[4];
	end

endmodule : exec_adder
`default_nettype wire

// *** design/exec_stack.sv ***
// hardware return stack held in flip-flops
`default_nettype none
module exec_stack
	import exec_pkg::*;
#(
	parameter int DEPTH = STACK_DEPTH_DEF
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic push,
	input wire logic pop,
	input wire logic [PC_W-1:0] push_val,
	output logic [PC_W-1:0] top
);
	localparam int SP_W = $clog2(DEPTH);
	logic [PC_W-1:0] mem_q [DEPTH];
	logic [SP_W-1:0] sp_q;
	logic [SP_W-1:0] top_idx;

	// pointer wraps on overflow and underflow
	assign top_idx = sp_q - SP_W'(1);
	assign top = mem_q[top_idx];

	always_ff @(posedge clk) begin
		if (rst) begin
			sp_q <= '0;
		end else if (push) begin
			sp_q <= sp_q + SP_W'(1);
		end else if (pop) begin
			sp_q <= top_idx;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
		end else if (push) begin
			mem_q[sp_q] <= push_val;
		end
	end

endmodule : exec_stack
`default_nettype wire

// *** verif/pm_model.sv ***
// program memory model answering instruction words combinationally
`default_nettype none
module pm_model
	import exec_pkg::*;
(
	input wire logic [PC_W-1:0] pm_addr,
	output logic [WORD_W-1:0] pm_word
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [WORD_W-1:0] mem [0:255];
	// word at address 0 under test, every other word zero
	task automatic load(input logic [WORD_W-1:0] w);
		for (int i = 0; i < 256; i++) begin
			mem[i] = '0;
		end
		mem[0] = w;
	endtask : load
	// outside the array the memory answers an unlisted all-ones word
	assign pm_word = (pm_addr < 15'h0100) ? mem[pm_addr[7:0]] : {WORD_W{1'b1}};
endmodule : pm_model
`default_nettype wire

// *** verif/mcu_instruction_execute_bench.sv ***
// self-checking bench for the instruction execute core
`default_nettype none
module mcu_instruction_execute_bench
	import exec_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, reg_wr, reg_rd, retire;
	logic [PC_W-1:0] pm_addr;
	logic [WORD_W-1:0] pm_word;
	logic [BUS_AW-1:0] reg_addr;
	logic [BUS_DW-1:0] reg_wdata, reg_rdata;
	int n_mismatch, comparisons, retired, ntest;
	logic [5:0] ops [0:12];
	mcu_instruction_execute #(.STACK_DEPTH(STACK_DEPTH_DEF)) mcu_instruction_execute_i (
		.clk(clk), .rst(rst), .pm_addr(pm_addr), .pm_word(pm_word), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.retire(retire));
	pm_model pm_model_i (.pm_addr(pm_addr), .pm_word(pm_word));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(negedge clk) if (retire === 1'b1) retired++;
	////////////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : summarize
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		d = reg_rdata;
	endtask : rd
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic is_file(input logic [13:0] w);
		return w[13:8] inside {OP_ADD_CARRY_FILE, OP_SUB_BORROW_FILE, OP_ROTATE_LEFT_CARRY,
			OP_ROTATE_RIGHT_CARRY, OP_DEC_SKIP_ZERO, OP_INC_SKIP_ZERO} || w[13:11] == 3'b011;
	endfunction : is_file
	function automatic void predict(input logic [13:0] w, input logic [7:0] a, f,
		input logic [2:0] s, output logic [7:0] na, nf, output logic [2:0] ns,
		output int lost, output logic ret);
		logic [8:0] t;
		logic [4:0] h;
		logic [7:0] r, inv;
		logic wf, ar;
		na = a;
		nf = f;
		ns = s;
		lost = 0;
		ret = 1'b0;
		wf = 1'b0;
		ar = 1'b0;
		inv = ~a;
		t = '0;
		h = '0;
		r = f;
		case (w[13:8])
			OP_ADD_CARRY_FILE: begin
				t = a + f + s[0];
				h = a[3:0] + f[3:0] + s[0];
				ar = 1'b1;
			end
			OP_SUB_BORROW_FILE: begin
				t = f + inv + s[0];
				h = f[3:0] + inv[3:0] + s[0];
				ar = 1'b1;
			end
			OP_ROTATE_LEFT_CARRY: begin
				r = {f[6:0], s[0]};
				ns[FLAG_C] = f[7];
				wf = 1'b1;
			end
			OP_ROTATE_RIGHT_CARRY: begin
				r = {s[0], f[7:1]};
				ns[FLAG_C] = f[0];
				wf = 1'b1;
			end
			OP_DEC_SKIP_ZERO, OP_INC_SKIP_ZERO: begin
				r = (w[13:8] == OP_DEC_SKIP_ZERO) ? f - 8'h01 : f + 8'h01;
				lost = (r == 8'h00);
				wf = 1'b1;
			end
			OP_LITERAL_OR: na = a | w[7:0];
			OP_LITERAL_AND: na = a & w[7:0];
			OP_LITERAL_XOR: na = a ^ w[7:0];
			OP_LITERAL_MINUS_ACC: begin
				t = w[7:0] + inv + 1'b1;
				h = w[3:0] + inv[3:0] + 1'b1;
				na = t[7:0];
				ns = {t[7:0] == 8'h00, h[4], t[8]};
			end
			OP_RETURN_WITH_LITERAL: begin
				na = w[7:0];
				ret = 1'b1;
			end
			default: begin
				ret = (w == OP_RETURN);
				if (w[13:11] == 3'b011) lost = (f[w[9:7]] == w[10]);
			end
		endcase
		if (w[13:8] inside {OP_LITERAL_OR, OP_LITERAL_AND, OP_LITERAL_XOR}) ns[FLAG_Z] = na == 0;
		if (ar) begin
			r = t[7:0];
			ns = {r == 8'h00, h[4], t[8]};
			wf = 1'b1;
		end
		if (wf && w[DEST_POS]) nf = r;
		if (wf && !w[DEST_POS]) na = r;
		if (ret) lost = 1;
	endfunction : predict
	////////////////////////////////////////////////////////////////////////////////
	task automatic one(input logic [13:0] w, input logic [7:0] a, f, input logic [2:0] s,
		input logic msb);
		logic [7:0] na, nf;
		logic [2:0] ns;
		logic ret, stall;
		logic [6:0] tgt;
		logic [15:0] v, n;
		int lost;
		predict(w, a, f, s, na, nf, ns, lost, ret);
		tgt = (w[6:0] == 7'h00) ? 7'h21 : w[6:0];
		stall = is_file(w) && w[6:0] == 7'h00 && msb;
		pm_model_i.load(w);
		@(posedge clk);
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		wr(REG_ACC, {8'h00, a});
		wr(REG_STATUS, {13'h0000, s});
		wr(REG_FILE_SEL, {9'h000, ADDR_POINTER_REGISTER});
		wr(REG_FILE_DATA, {8'h00, msb, 7'h21});
		wr(REG_FILE_SEL, {9'h000, tgt});
		wr(REG_FILE_DATA, {8'h00, f});
		wr(REG_STACK_PUSH, 16'h0040);
		retired = 0;
		wr(REG_CTRL, 16'h0001);
		repeat (4) @(posedge clk);
		// refused while running: accumulator must keep the executed result
		wr(REG_ACC, 16'h00a5);
		wr(REG_CTRL, 16'h0000);
		rd(REG_CYCLES, n);
		chk(16'(retired), n - 16'(lost) - 16'(stall));
		rd(REG_PC, v);
		chk(v, ret ? 16'h0040 + n - 16'h0002 : n - 16'(stall));
		chk({1'b0, pm_addr}, ret ? 16'h0040 + n - 16'h0002 : n - 16'(stall));
		rd(REG_CTRL, v);
		chk(v, 16'h0000);
		rd(REG_ACC, v);
		chk(v, {8'h00, na});
		rd(REG_STATUS, v);
		chk(v, {13'h0000, ns});
		rd(REG_PC_HIGH_LATCH, v);
		chk(v, (w[13:7] == OP_LITERAL_TO_PAGE_LATCH) ? {9'h000, w[6:0]} : 16'h0000);
		wr(REG_FILE_SEL, {9'h000, tgt});
		rd(REG_FILE_DATA, v);
		chk(v, {8'h00, nf});
		ntest++;
		$display("test %0d word %h done", ntest, w);
	endtask : one
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [5:0] op;
		logic [13:0] w;
		logic [15:0] v;
		logic ind;
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		void'($urandom(32'h8c6a3090));
		ops = '{OP_ADD_CARRY_FILE, OP_SUB_BORROW_FILE, OP_ROTATE_LEFT_CARRY,
			OP_ROTATE_RIGHT_CARRY, OP_DEC_SKIP_ZERO, OP_INC_SKIP_ZERO, OP_LITERAL_OR,
			OP_LITERAL_AND, OP_LITERAL_XOR, OP_LITERAL_MINUS_ACC, OP_RETURN_WITH_LITERAL,
			{OP_BIT_TEST_SKIP_CLEAR, 2'b00}, {OP_BIT_TEST_SKIP_SET, 2'b00}};
		one({OP_ADD_CARRY_FILE, 8'h30}, 8'h00, 8'hff, 3'h1, 1'b0);
		one({OP_ROTATE_LEFT_CARRY, 8'h30}, 8'h00, 8'he6, 3'h0, 1'b0);
		one({OP_DEC_SKIP_ZERO, 8'h80}, 8'h11, 8'h01, 3'h5, 1'b1);
		one({OP_INC_SKIP_ZERO, 8'h31}, 8'h22, 8'hff, 3'h2, 1'b0);
		one({OP_BIT_TEST_SKIP_SET, 3'h7, 7'h30}, 8'h33, 8'h80, 3'h7, 1'b0);
		one(OP_RETURN, 8'h44, 8'h00, 3'h3, 1'b0);
		one({OP_LITERAL_TO_PAGE_LATCH, 7'h5a}, 8'h55, 8'h00, 3'h4, 1'b0);
		one(14'h3fff, 8'h66, 8'h12, 3'h6, 1'b0);
		one({OP_LITERAL_MINUS_ACC, 8'h05}, 8'h05, 8'h00, 3'h0, 1'b0);
		rd(4'hf, v);
		chk(v, 16'h0000);
		@(negedge clk);
		chk(reg_rdata, 16'h0000);
		repeat (60) begin
			op = ops[$urandom % 13];
			if (op[5:3] == 3'b011) op[1:0] = 2'($urandom);
			w = {op, 8'($urandom)};
			ind = ($urandom % 3) == 0;
			if (is_file(w)) w[6:0] = ind ? 7'h00 : 7'h30 + 7'($urandom % 64);
			one(w, 8'($urandom), 8'($urandom), 3'($urandom), ind && 1'($urandom));
		end
		summarize();
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		summarize();
	end
endmodule : mcu_instruction_execute_bench
`default_nettype wire
